/* core/light_curtain_control.sv */
// supervision and reprogramming of a safety light curtain
`timescale 1ns/1ns
module light_curtain_control
  import light_curtain_pkg::*;
#(
  parameter int TICKS = TICK_CYCLES
) (
  // clock, reset, clock enable
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  input wire logic clk_en_i,
  // control side
  input wire logic curtain_mode_enable_i,
  input wire logic reprogram_request_i,
  input wire logic start_input_i,
  // configuration
  input wire logic auto_start_i,
  input wire logic [HOLD_W-1:0] hold_time_i,
  input wire logic [REPEAT_W-1:0] repeat_count_i,
  input wire logic [MODE_COUNT-1:0] mode_select_i,
  // sensor side
  input wire logic safety_channel_a_i,
  input wire logic safety_channel_b_i,
  output logic transmitter_supply_o,
  output logic receiver_supply_o,
  // programming interface
  output logic prog_strobe_o,
  output logic [MODE_IDX_W-1:0] prog_mode_o,
  // outputs and flags
  output logic enable_output_o,
  output logic error_output_o,
  output logic transfer_active_flag_o,
  output logic timer_active_flag_o,
  output logic channel_discrepancy_flag_o,
  output logic safety_output_started_flag_o
);

  typedef struct packed {
    lc_state_t state;
    logic start_prev;
    logic both_high_prev;
    logic start_seen;
    logic [MODE_IDX_W-1:0] mode_idx;
    logic [REPEAT_W-1:0] rep_cnt;
    logic [GAP_W-1:0] gap_cnt;
    logic tx;
    logic rx;
    logic en;
    logic err;
    logic xfer_flag;
    logic timer_flag;
    logic disc_flag;
    logic started_flag;
    logic prog_strobe;
  } lc_ctrl_t;

  localparam lc_ctrl_t CTRL_RST = '{
    state: ST_OFF,
    start_prev: 1'b0,
    both_high_prev: 1'b0,
    start_seen: 1'b0,
    mode_idx: MODE_IDX_RST,
    rep_cnt: {REPEAT_W{1'b0}},
    gap_cnt: {GAP_W{1'b0}},
    tx: 1'b0,
    rx: 1'b0,
    en: 1'b0,
    err: 1'b0,
    xfer_flag: 1'b0,
    timer_flag: 1'b0,
    disc_flag: 1'b0,
    started_flag: 1'b0,
    prog_strobe: 1'b0
  };

  lc_ctrl_t s_r;
  lc_ctrl_t s_nxt;

  logic timer_start;
  logic timer_abort;
  logic timer_active;
  logic timer_done;
  logic both_high;
  logic both_low;
  logic disagree;
  logic start_event;
  logic [HOLD_W-1:0] rep_wide;

  hold_timer #(
    .TICKS(TICKS)
  ) u_hold_timer (
    .core_clk_i(core_clk_i),
    .sys_rst_i(sys_rst_i),
    .clk_en_i(clk_en_i),
    .start_i(timer_start),
    .abort_i(timer_abort),
    .hold_i(hold_time_i),
    .active_o(timer_active),
    .done_o(timer_done)
  );

  always_comb begin
    both_high = safety_channel_a_i & safety_channel_b_i;
    both_low = ~safety_channel_a_i & ~safety_channel_b_i;
    disagree = safety_channel_a_i ^ safety_channel_b_i;
    if (auto_start_i) begin
      start_event = both_high & ~s_r.both_high_prev;
    end else begin
      // press and release needed; a held button never starts
      start_event = s_r.start_prev & ~start_input_i & both_high;
    end
    rep_wide = clamp16({8'h00, repeat_count_i}, {8'h00, REPEAT_MIN}, {8'h00, REPEAT_MAX});

    s_nxt = s_r;
    s_nxt.prog_strobe = 1'b0;
    s_nxt.start_prev = start_input_i;
    s_nxt.both_high_prev = both_high;
    s_nxt.timer_flag = timer_active & curtain_mode_enable_i;
    timer_start = 1'b0;
    timer_abort = 1'b0;

    if (!curtain_mode_enable_i) begin
      s_nxt = CTRL_RST;
      s_nxt.start_prev = start_input_i;
      s_nxt.both_high_prev = both_high;
      timer_abort = 1'b1;
    end else if ((s_r.state == ST_OFF || s_r.state == ST_RUN) && reprogram_request_i) begin
      s_nxt.tx = 1'b1;
      s_nxt.rx = 1'b0;
      s_nxt.en = 1'b0;
      s_nxt.start_seen = 1'b0;
      s_nxt.started_flag = 1'b0;
      s_nxt.disc_flag = 1'b0;
      if (mode_select_i == '0) begin
        s_nxt.err = 1'b1;
        s_nxt.state = ST_ERROR;
      end else begin
        s_nxt.mode_idx = first_mode(mode_select_i);
        s_nxt.rep_cnt = rep_wide[REPEAT_W-1:0];
        timer_start = 1'b1;
        s_nxt.state = ST_HOLD;
      end
    end else begin
      case (s_r.state)
        ST_OFF, ST_RUN: begin
          s_nxt.state = ST_RUN;
          s_nxt.tx = 1'b1;
          s_nxt.rx = 1'b1;
          s_nxt.err = 1'b0;
          if (both_low) begin
            s_nxt.start_seen = 1'b0;
          end else if (start_event) begin
            s_nxt.start_seen = 1'b1;
          end
          s_nxt.disc_flag = disagree;
          s_nxt.en = both_high & s_nxt.start_seen;
          s_nxt.started_flag = s_nxt.start_seen & ~disagree;
        end
        ST_HOLD: begin
          s_nxt.rx = 1'b0;
          if (!reprogram_request_i) begin
            // request dropped too early: programming abandoned
            timer_abort = 1'b1;
            // flag must not outlive the aborted wait with rx back on
            s_nxt.timer_flag = 1'b0;
            s_nxt.state = ST_RUN;
            s_nxt.rx = 1'b1;
          end else if (timer_done) begin
            s_nxt.rx = 1'b1;
            s_nxt.xfer_flag = 1'b1;
            s_nxt.gap_cnt = '0;
            s_nxt.state = ST_XFER;
          end
        end
        ST_XFER: begin
          if (s_r.gap_cnt == XFER_GAP_CYCLES - GAP_W'(1)) begin
            s_nxt.gap_cnt = '0;
            s_nxt.prog_strobe = 1'b1;
            s_nxt.rep_cnt = s_r.rep_cnt - REPEAT_W'(1);
            if (s_r.rep_cnt == REPEAT_W'(1)) begin
              s_nxt.xfer_flag = 1'b0;
              s_nxt.state = ST_RELEASE;
            end
          end else begin
            s_nxt.gap_cnt = s_r.gap_cnt + GAP_W'(1);
          end
        end
        ST_RELEASE: begin
          // a new request needs the old one released first
          if (!reprogram_request_i) begin
            s_nxt.state = ST_RUN;
          end
        end
        ST_ERROR: begin
          if (!reprogram_request_i) begin
            s_nxt.err = 1'b0;
            s_nxt.rx = 1'b1;
            s_nxt.state = ST_RUN;
          end
        end
        default: begin
          s_nxt = CTRL_RST;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      s_r <= CTRL_RST;
    end else if (clk_en_i) begin
      s_r <= s_nxt;
    end
  end

  assign transmitter_supply_o = s_r.tx;
  assign receiver_supply_o = s_r.rx;
  assign enable_output_o = s_r.en;
  assign error_output_o = s_r.err;
  assign transfer_active_flag_o = s_r.xfer_flag;
  assign timer_active_flag_o = s_r.timer_flag;
  assign channel_discrepancy_flag_o = s_r.disc_flag;
  assign safety_output_started_flag_o = s_r.started_flag;
  assign prog_strobe_o = s_r.prog_strobe;
  assign prog_mode_o = s_r.mode_idx;

endmodule

/* core/light_curtain_pkg.sv */
// shared constants, limits and types for the light curtain controller
package light_curtain_pkg;

  // clock and holding timer base
  localparam int CLK_PERIOD_NS = 10;
  localparam int TICK_PERIOD_US = 10_000;
  localparam int TICK_CYCLES = (TICK_PERIOD_US * 1000) / CLK_PERIOD_NS;
  localparam int PRESCALE_W = 20;

  // holding time in hundredths of a second
  localparam int HOLD_W = 16;
  localparam logic [HOLD_W-1:0] HOLD_MIN = 16'h0001;
  localparam logic [HOLD_W-1:0] HOLD_MAX = 16'hea5f;
  localparam logic [HOLD_W-1:0] HOLD_RECOMMENDED = 16'h0032;

  // number of mode transmissions per reprogramming
  localparam int REPEAT_W = 8;
  localparam logic [REPEAT_W-1:0] REPEAT_MIN = 8'h32;
  localparam logic [REPEAT_W-1:0] REPEAT_MAX = 8'hfa;

  // spacing between two mode transmissions, in clock cycles
  localparam int GAP_W = 8;
  localparam logic [GAP_W-1:0] XFER_GAP_CYCLES = 8'h10;

  // operating mode selection inputs
  localparam int MODE_COUNT = 16;
  localparam int MODE_IDX_W = 5;
  localparam logic [MODE_IDX_W-1:0] MODE_IDX_RST = 5'h00;

  typedef enum {ST_OFF, ST_RUN, ST_HOLD, ST_XFER, ST_RELEASE, ST_ERROR} lc_state_t;

  // lowest-numbered selected mode wins
  function automatic logic [MODE_IDX_W-1:0] first_mode(input logic [MODE_COUNT-1:0] sel);
    logic [MODE_IDX_W-1:0] idx;
    idx = MODE_IDX_RST;
    for (int i = MODE_COUNT - 1; i >= 0; i--) begin
      if (sel[i]) begin
        idx = MODE_IDX_W'(i);
      end
    end
    return idx;
  endfunction

  // clamp a configured value into its allowed window
  function automatic logic [HOLD_W-1:0] clamp16(input logic [HOLD_W-1:0] v,
                                                input logic [HOLD_W-1:0] lo,
                                                input logic [HOLD_W-1:0] hi);
    logic [HOLD_W-1:0] r;
    r = v;
    if (v < lo) begin
      r = lo;
    end else if (v > hi) begin
      r = hi;
    end
    return r;
  endfunction

endpackage

/* core/hold_timer.sv */
// holding timer counting in hundredths of a second
`timescale 1ns/1ns
module hold_timer
  import light_curtain_pkg::*;
#(
  parameter int TICKS = TICK_CYCLES
) (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  input wire logic clk_en_i,
  // control
  input wire logic start_i,
  input wire logic abort_i,
  input wire logic [HOLD_W-1:0] hold_i,
  // status
  output logic active_o,
  output logic done_o
);

  typedef struct packed {
    logic active;
    logic done;
    logic [PRESCALE_W-1:0] prescale;
    logic [HOLD_W-1:0] remaining;
  } timer_state_t;

  localparam timer_state_t TIMER_RST = '{1'b0, 1'b0, {PRESCALE_W{1'b0}}, {HOLD_W{1'b0}}};
  localparam logic [PRESCALE_W-1:0] PRESCALE_LAST = PRESCALE_W'(TICKS - 1);

  timer_state_t s_r;
  timer_state_t s_nxt;

  always_comb begin
    s_nxt = s_r;
    s_nxt.done = 1'b0;
    if (abort_i) begin
      s_nxt.active = 1'b0;
      s_nxt.prescale = '0;
    end else if (start_i) begin
      // zero is taken as the shortest legal time
      s_nxt.active = 1'b1;
      s_nxt.prescale = '0;
      s_nxt.remaining = clamp16(hold_i, HOLD_MIN, HOLD_MAX);
    end else if (s_r.active) begin
      if (s_r.prescale == PRESCALE_LAST) begin
        s_nxt.prescale = '0;
        if (s_r.remaining == HOLD_MIN) begin
          s_nxt.active = 1'b0;
          s_nxt.done = 1'b1;
        end
        s_nxt.remaining = s_r.remaining - HOLD_MIN;
      end else begin
        s_nxt.prescale = s_r.prescale + PRESCALE_W'(1);
      end
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      s_r <= TIMER_RST;
    end else if (clk_en_i) begin
      s_r <= s_nxt;
    end
  end

  assign active_o = s_r.active;
  assign done_o = s_r.done;

endmodule

/* bench/light_curtain_control_properties.sv */
// port assertions for the light curtain controller
`timescale 1ns/1ns
module light_curtain_control_properties
  import light_curtain_pkg::*;
(
  // clock and controls
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  input wire logic clk_en_i,
  input wire logic curtain_mode_enable_i,
  input wire logic reprogram_request_i,
  input wire logic [MODE_COUNT-1:0] mode_select_i,
  input wire logic safety_channel_a_i,
  input wire logic safety_channel_b_i,
  // watched outputs
  input wire logic transmitter_supply_o,
  input wire logic receiver_supply_o,
  input wire logic prog_strobe_o,
  input wire logic enable_output_o,
  input wire logic error_output_o,
  input wire logic transfer_active_flag_o,
  input wire logic timer_active_flag_o,
  input wire logic channel_discrepancy_flag_o,
  input wire logic safety_output_started_flag_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (sys_rst_i);
  wire md = curtain_mode_enable_i;
  wire rq = reprogram_request_i;
  wire tx = transmitter_supply_o;
  wire rx = receiver_supply_o;
  wire en = enable_output_o;
  wire xf = transfer_active_flag_o;
  logic ok_r;
  // enable may only follow a cycle with every condition met
  always_ff @(posedge core_clk_i) begin
    if (clk_en_i) begin
      ok_r <= md && !rq && safety_channel_a_i && safety_channel_b_i;
    end
  end
  a_mode_off_quiet: assert property (clk_en_i && !md |=>
    !tx && !rx && !en && !error_output_o) else $error("outputs active with mode off");
  a_supply_on: assert property (clk_en_i && $rose(md) && !rq |=> tx && rx)
    else $error("supplies not switched on");
  a_enable_cause: assert property (en |-> ok_r)
    else $error("enable without its conditions");
  a_disc_blocks_en: assert property (clk_en_i && md && !rq && !xf
    && !timer_active_flag_o && (safety_channel_a_i != safety_channel_b_i)
    |=> !en && tx && rx && channel_discrepancy_flag_o) else $error("discrepancy missed");
  a_started_clean: assert property (safety_output_started_flag_o
    |-> !channel_discrepancy_flag_o) else $error("started with discrepancy");
  a_req_tx_on: assert property (clk_en_i && md && rq |=> tx && !en)
    else $error("request supply state wrong");
  a_req_rx_off: assert property (clk_en_i && md && $rose(rq) |=> !rx)
    else $error("receiver not off on request");
  a_hold_rx_off: assert property (timer_active_flag_o |-> !rx)
    else $error("receiver on while timer runs");
  a_xfer_supplies: assert property (xf |-> tx && rx)
    else $error("transfer without supplies");
  a_strobe_in_xfer: assert property (prog_strobe_o |-> $past(xf))
    else $error("strobe outside transfer");
  a_no_mode_err: assert property (clk_en_i && md && $rose(rq) && mode_select_i == '0
    |-> ##[1:3] (error_output_o && !xf)) else $error("missing mode not flagged");
  a_reset_clear: assert property (disable iff (1'b0) sys_rst_i |=> !tx && !rx && !en
    && !error_output_o && !xf && !timer_active_flag_o && !channel_discrepancy_flag_o
    && !safety_output_started_flag_o && !prog_strobe_o) else $error("reset left output set");
endmodule
bind light_curtain_control light_curtain_control_properties i_props (.*);

/* bench/curtain_model.sv */
// behavioural light curtain answering the supply outputs
`timescale 1ns/1ns
module curtain_model (
  input wire logic core_clk_i,
  input wire logic tx_i,
  input wire logic rx_i,
  input wire logic strobe_i,
  input wire logic cut_a_i,
  input wire logic cut_b_i,
  output logic chan_a_o,
  output logic chan_b_o,
  output int strobes_o
);
  // channels only clear while both supplies are on and the beam is free
  assign chan_a_o = tx_i && rx_i && !cut_a_i;
  assign chan_b_o = tx_i && rx_i && !cut_b_i;
  initial strobes_o = 0;
  always @(posedge core_clk_i) if (strobe_i) strobes_o <= strobes_o + 1;
endmodule

/* bench/light_curtain_control_tb.sv */
// self-checking bench for the light curtain controller
`timescale 1ns/1ns
module light_curtain_control_tb;
  import light_curtain_pkg::*;
  localparam int TK = 4;
  logic core_clk_i = 0, sys_rst_i = 1, clk_en_i = 1, curtain_mode_enable_i = 0;
  logic reprogram_request_i = 0, start_input_i = 0, auto_start_i = 0, cut_a = 0, cut_b = 0;
  logic [HOLD_W-1:0] hold_time_i = HOLD_RECOMMENDED;
  logic [REPEAT_W-1:0] repeat_count_i = REPEAT_MIN;
  logic [MODE_COUNT-1:0] mode_select_i = 16'h0001;
  logic safety_channel_a_i, safety_channel_b_i, transmitter_supply_o, receiver_supply_o;
  logic prog_strobe_o, enable_output_o, error_output_o, transfer_active_flag_o;
  logic timer_active_flag_o, channel_discrepancy_flag_o, safety_output_started_flag_o;
  logic [MODE_IDX_W-1:0] prog_mode_o;
  int n_fail = 0, total_checks = 0, cycles = 0, strobes, nt, n;
  integer seed = 32'hf442608f;
  wire [3:0] outs = {transmitter_supply_o, receiver_supply_o, enable_output_o, error_output_o};
  wire [3:0] flags = {transfer_active_flag_o, timer_active_flag_o,
    channel_discrepancy_flag_o, safety_output_started_flag_o};

  light_curtain_control #(.TICKS(TK)) i_light_curtain_control (.*);
  curtain_model i_curtain_model (.core_clk_i(core_clk_i), .tx_i(transmitter_supply_o),
    .rx_i(receiver_supply_o), .strobe_i(prog_strobe_o), .cut_a_i(cut_a), .cut_b_i(cut_b),
    .chan_a_o(safety_channel_a_i), .chan_b_o(safety_channel_b_i), .strobes_o(strobes));

  always #5 core_clk_i = ~core_clk_i;

  function automatic logic [MODE_IDX_W-1:0] lowest(input logic [MODE_COUNT-1:0] s);
    lowest = '0;
    for (int i = MODE_COUNT - 1; i >= 0; i--) if (s[i]) lowest = MODE_IDX_W'(i);
  endfunction

  function automatic logic [REPEAT_W-1:0] reps(input logic [REPEAT_W-1:0] r);
    return r < REPEAT_MIN ? REPEAT_MIN : (r > REPEAT_MAX ? REPEAT_MAX : r);
  endfunction

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // k rising edges, then read settled values at the falling edge
  task automatic settle(input int k);
    repeat (k) @(posedge core_clk_i);
    @(negedge core_clk_i);
  endtask

  task automatic cut(input logic [1:0] v);
    @(posedge core_clk_i) {cut_a, cut_b} <= v;
    settle(2);
  endtask

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  always @(posedge core_clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      n_fail++;
      print_verdict;
    end
  end

  initial begin
    settle(19);
    chk({outs, flags}, 8'h00);
    @(posedge core_clk_i) sys_rst_i <= 0;
    repeat (12) begin
      @(posedge core_clk_i);
      {reprogram_request_i, start_input_i, cut_a, cut_b} <= 4'($random(seed));
      mode_select_i <= 16'($random(seed));
      settle(0);
      @(posedge core_clk_i);
      @(negedge core_clk_i);
      chk(outs, 4'h0);
    end
    @(posedge core_clk_i);
    {reprogram_request_i, start_input_i, cut_a, cut_b} <= '0;
    curtain_mode_enable_i <= 1;
    settle(1);
    chk(outs, 4'hc);
    settle(4);
    @(posedge core_clk_i) start_input_i <= 1;
    settle(3);
    chk(outs, 4'hc);
    @(posedge core_clk_i) start_input_i <= 0;
    settle(2);
    chk({outs, flags}, 8'he1);
    cut(2'b10);
    chk({outs, flags}, 8'hc2);
    cut(2'b11);
    cut(2'b00);
    settle(1);
    chk(outs, 4'hc);
    @(posedge core_clk_i) auto_start_i <= 1;
    cut(2'b11);
    cut(2'b00);
    chk(outs, 4'he);
    // clock enable low: beam cut must not act until it returns
    @(posedge core_clk_i);
    clk_en_i <= 0;
    {cut_a, cut_b} <= 2'b11;
    settle(3);
    chk(outs, 4'he);
    @(posedge core_clk_i) clk_en_i <= 1;
    settle(1);
    chk(outs, 4'hc);
    cut(2'b00);
    chk(outs, 4'he);
    @(posedge core_clk_i);
    reprogram_request_i <= 1;
    mode_select_i <= 16'($random(seed)) | 16'h8000;
    repeat_count_i <= 8'($random(seed));
    settle(1);
    chk(outs, 4'h8);
    n = 0;
    nt = 0;
    while (transfer_active_flag_o !== 1'b1 && n < 1000) begin
      if (timer_active_flag_o === 1'b1) nt++;
      settle(1);
      n++;
    end
    n = nt - int'(hold_time_i) * TK;
    chk(16'(n >= -2 && n <= 2), 16'h1);
    chk(outs & 4'h4, 4'h4);
    n = 0;
    while (transfer_active_flag_o !== 1'b0 && n < 5000) begin
      settle(1);
      n++;
    end
    settle(2);
    chk(16'(strobes), 16'(reps(repeat_count_i)));
    chk(16'(prog_mode_o), 16'(lowest(mode_select_i)));
    @(posedge core_clk_i) reprogram_request_i <= 0;
    settle(3);
    @(posedge core_clk_i);
    mode_select_i <= '0;
    reprogram_request_i <= 1;
    settle(4);
    chk({outs, flags}, 8'h90);
    @(posedge core_clk_i) reprogram_request_i <= 0;
    settle(3);
    chk(outs & 4'hd, 4'hc);
    // request dropped while the timer still runs: aborted, receiver back
    @(posedge core_clk_i);
    mode_select_i <= 16'h0004;
    reprogram_request_i <= 1;
    settle(20);
    chk({outs, flags}, 8'h84);
    @(posedge core_clk_i) reprogram_request_i <= 0;
    settle(2);
    chk({outs & 4'hd, flags & 4'hc}, 8'hc0);
    @(posedge core_clk_i) curtain_mode_enable_i <= 0;
    settle(1);
    chk(outs, 4'h0);
    print_verdict;
  end
endmodule
